// ---- inc/mcdec_consts.vh ----
`ifndef MCDEC_CONSTS_VH
`define MCDEC_CONSTS_VH

// Clocks per machine cycle.
`define MCDEC_CLK_PER_MC 2

// Instruction byte lengths.
`define MCDEC_LEN_1     2'd1
`define MCDEC_LEN_2     2'd2
`define MCDEC_LEN_3     2'd3

// Execution times in machine cycles.
`define MCDEC_MC_W      3
`define MCDEC_MC_1      3'd1
`define MCDEC_MC_2      3'd2
`define MCDEC_MC_4      3'd4

// Operation classes.
`define MCDEC_OP_W      5
`define MCDEC_OP_NONE   5'h00
`define MCDEC_OP_ADD    5'h01
`define MCDEC_OP_ADDC   5'h02
`define MCDEC_OP_SUBB   5'h03
`define MCDEC_OP_INC    5'h04
`define MCDEC_OP_DEC    5'h05
`define MCDEC_OP_MUL    5'h06
`define MCDEC_OP_DIV    5'h07
`define MCDEC_OP_DA     5'h08
`define MCDEC_OP_AND    5'h09
`define MCDEC_OP_OR     5'h0a
`define MCDEC_OP_XOR    5'h0b
`define MCDEC_OP_CLR    5'h0c
`define MCDEC_OP_CPL    5'h0d
`define MCDEC_OP_SWAP   5'h0e
`define MCDEC_OP_RL     5'h0f
`define MCDEC_OP_RLC    5'h10
`define MCDEC_OP_RR     5'h11
`define MCDEC_OP_RRC    5'h12
`define MCDEC_OP_MOV    5'h13
`define MCDEC_OP_MOVC   5'h14
`define MCDEC_OP_MOVX   5'h15
`define MCDEC_OP_PUSH   5'h16
`define MCDEC_OP_POP    5'h17
`define MCDEC_OP_XCH    5'h18
`define MCDEC_OP_XCHD   5'h19
`define MCDEC_OP_SETB   5'h1a
`define MCDEC_OP_ANLC   5'h1b

// Operand locations.
`define MCDEC_LOC_W     4
`define MCDEC_LOC_NONE  4'h0
`define MCDEC_LOC_ACC   4'h1
`define MCDEC_LOC_REG   4'h2
`define MCDEC_LOC_DIR   4'h3
`define MCDEC_LOC_IND   4'h4
`define MCDEC_LOC_IMM   4'h5
`define MCDEC_LOC_DATA_POINTER16  4'h6
`define MCDEC_LOC_CODEA 4'h7
`define MCDEC_LOC_CODEP 4'h8
`define MCDEC_LOC_XIND  4'h9
`define MCDEC_LOC_XDPTR 4'ha
`define MCDEC_LOC_CARRY 4'hb
`define MCDEC_LOC_BIT   4'hc
`define MCDEC_LOC_STACK 4'hd
`define MCDEC_LOC_IMM16 4'he
`define MCDEC_LOC_INDLO 4'hf

// Low opcode bits pick the bank register.
`define MCDEC_REG_LSB   0
`define MCDEC_REG_W     3

`endif

// ---- rtl/mcdec_mc_timer.v ----
`include "mcdec_consts.vh"

// Counts machine cycles of two clocks each for the execution sequencer.
module mcdec_mc_timer #(
	parameter CNT_W = 3
) (
	input  wire             i_clk,
	input  wire             i_nrst,
	input  wire             i_start,
	input  wire [CNT_W-1:0] i_cycles,
	output reg              o_busy,
	output reg              o_done
);
	reg [CNT_W-1:0] mc_reg;
	reg             phase_reg;

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mc_reg    <= {CNT_W{1'b0}};
			phase_reg <= 1'b0;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start && !o_busy) begin
				mc_reg    <= i_cycles;
				phase_reg <= 1'b0;
				o_busy    <= 1'b1;
			end else if (o_busy) begin
				// Phase toggles each clock, so one machine cycle is two clocks. [RL2]
				phase_reg <= ~phase_reg;
				if (phase_reg) begin
					mc_reg <= mc_reg - {{(CNT_W-1){1'b0}}, 1'b1};
					if (mc_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						o_busy <= 1'b0;
						o_done <= 1'b1;
					end
				end
			end
		end
	end
endmodule // mcdec_mc_timer

// ---- rtl/mcdec_opcode_decoder.v ----
`include "mcdec_consts.vh"

// How it works
// (RL1) Every defined opcode reports a length of one, two or three bytes.
// (RL2) A machine cycle is two clocks; times count whole machine cycles.
// (RL3) Multiply A4 and divide 84 are one byte, four cycles.
// (RL4) Add: register 28-2F, direct 25, indirect 26-27, immediate 24; one cycle.
// (RL5) Add with carry: 38-3F, 35, 36-37, 34; one cycle each.
// (RL6) Subtract with borrow: 98-9F, 95, 96-97, 94; one cycle each.
// (RL7) Increment 04, 08-0F, 05, 06-07 one cycle; pointer increment A3 two.
// (RL8) Decrement 14, 18-1F, 15, 16-17 and decimal adjust D4 one cycle.
// (RL9) AND 58-5F, 55, 56-57, 54, 52 one cycle; 53 three bytes two cycles.
// (RL10) OR 48-4F, 45, 46-47, 44, 42 one cycle; 43 three bytes two cycles.
// (RL11) XOR 68-6F, 65, 66-67, 64, 62 one cycle; 63 three bytes two cycles.
// (RL12) Clear E4, complement F4, swap C4, rotates 23, 33, 03, 13: one cycle.
// (RL13) Loads to A: E8-EF, E5, E6-E7, 74; one cycle each.
// (RL14) Bank register from A F8-FF one, direct A8-AF two, immediate 78-7F one.
// (RL15) Direct from A F5 one cycle; 88-8F, 86-87, 85, 75 two cycles.
// (RL16) Indirect from A F6-F7 one, direct A6-A7 two, immediate 76-77 one.
// (RL17) Code reads 93 and 83 two cycles; pointer load 90 three bytes two.
// (RL18) External transfers E2-E3, F2-F3, E0, F0 take two cycles.
// (RL19) Push C0 and pop D0 are two bytes, two cycles.
// (RL20) Exchanges C8-CF, C5, C6-C7 and nibble exchange D6-D7 one cycle.
// (RL21) Bit ops C3, C2, D3, D2, B3, B2 one cycle; bit forms two bytes.
// (RL22) AND bit into carry 82 is two bytes, two cycles.
// (RL23) Eight-code blocks take the bank register from the low three opcode bits.
// (RL24) Class, source, destination, length and cycles appear in the cycle after the fetch cycle.
module mcdec_opcode_decoder #(
	parameter CNT_W = 3
) (
	input  wire                    i_clk,
	input  wire                    i_nrst,
	input  wire                    i_opcode_valid,
	input  wire [7:0]              i_opcode,
	output reg                     o_valid,
	output reg                     o_defined,
	output reg  [`MCDEC_OP_W-1:0]  o_op,
	output reg  [`MCDEC_LOC_W-1:0] o_src,
	output reg  [`MCDEC_LOC_W-1:0] o_dst,
	output reg  [1:0]              o_len,
	output reg  [CNT_W-1:0]        o_cycles,
	output reg  [`MCDEC_REG_W-1:0] o_bank_register,
	output reg                     o_exec_busy,
	output reg                     o_exec_done
);
	reg [`MCDEC_OP_W-1:0]  op_next;
	reg [`MCDEC_LOC_W-1:0] src_next;
	reg [`MCDEC_LOC_W-1:0] dst_next;
	reg [1:0]              len_next;
	reg [CNT_W-1:0]        cyc_next;
	reg                    def_next;
	wire                   busy_w;
	wire                   done_w;
	wire                   accept_w;

	// Operand of a four-group ALU column: low nibble 4 imm, 5 dir, 6-7 ind, 8-F reg.
	function [`MCDEC_LOC_W-1:0] alu_src;
		input [3:0] lo;
		begin
			if (lo[3])
				alu_src = `MCDEC_LOC_REG;
			else if (lo[2:1] == 2'b11)
				alu_src = `MCDEC_LOC_IND;
			else if (lo[0])
				alu_src = `MCDEC_LOC_DIR;
			else
				alu_src = `MCDEC_LOC_IMM;
		end
	endfunction

	// Direct and immediate forms carry one operand byte.
	function [1:0] src_len;
		input [`MCDEC_LOC_W-1:0] loc;
		begin
			if (loc == `MCDEC_LOC_DIR || loc == `MCDEC_LOC_IMM)
				src_len = `MCDEC_LEN_2;
			else
				src_len = `MCDEC_LEN_1;
		end
	endfunction

	// Widens a machine-cycle count to the timer's counter width.
	function [CNT_W-1:0] mc_cnt;
		input [`MCDEC_MC_W-1:0] mc;
		begin
			mc_cnt                  = {CNT_W{1'b0}};
			mc_cnt[`MCDEC_MC_W-1:0] = mc;
		end
	endfunction

	// Every path starts from these defaults, so no branch can leave a latch behind.
	always @* begin
		op_next  = `MCDEC_OP_NONE;
		src_next = `MCDEC_LOC_NONE;
		dst_next = `MCDEC_LOC_NONE;
		len_next = `MCDEC_LEN_1;
		cyc_next = mc_cnt(`MCDEC_MC_1);
		def_next = 1'b1;
		// ALU column, low nibble 4 to F, for add/addc/subb/or/and/xor.
		if (i_opcode[3:0] >= 4'h4 && (i_opcode[7:4] == 4'h2 || i_opcode[7:4] == 4'h3 ||
			i_opcode[7:4] == 4'h9 || i_opcode[7:4] == 4'h4 || i_opcode[7:4] == 4'h5 ||
			i_opcode[7:4] == 4'h6) ) begin
			src_next = alu_src(i_opcode[3:0]);
			dst_next = `MCDEC_LOC_ACC;
			len_next = src_len(alu_src(i_opcode[3:0])); // [RL1]
			case (i_opcode[7:4])
				4'h2: op_next = `MCDEC_OP_ADD; // [RL4]
				4'h3: op_next = `MCDEC_OP_ADDC; // [RL5]
				4'h9: op_next = `MCDEC_OP_SUBB; // [RL6]
				4'h4: op_next = `MCDEC_OP_OR; // [RL10]
				4'h5: op_next = `MCDEC_OP_AND; // [RL9]
				default: op_next = `MCDEC_OP_XOR; // [RL11]
			endcase
		end else if (i_opcode[3:0] >= 4'h5 && (i_opcode[7:4] == 4'h0 ||
			i_opcode[7:4] == 4'h1 || i_opcode[7:4] == 4'he)) begin
			// Increment, decrement, load A; the 4 slot is handled below.
			src_next = alu_src(i_opcode[3:0]);
			dst_next = src_next;
			len_next = src_len(src_next);
			if (i_opcode[7:4] == 4'h0)
				op_next = `MCDEC_OP_INC; // [RL7]
			else if (i_opcode[7:4] == 4'h1)
				op_next = `MCDEC_OP_DEC; // [RL8]
			else begin
				op_next  = `MCDEC_OP_MOV; // [RL13]
				dst_next = `MCDEC_LOC_ACC;
			end
		end else if (i_opcode[7:4] == 4'hf && i_opcode[3:0] >= 4'h5) begin
			op_next  = `MCDEC_OP_MOV; // [RL14] [RL15] [RL16]
			src_next = `MCDEC_LOC_ACC;
			dst_next = alu_src(i_opcode[3:0]);
			len_next = src_len(dst_next);
		end else if (i_opcode[7:4] == 4'hc && i_opcode[3:0] >= 4'h5) begin
			op_next  = `MCDEC_OP_XCH; // [RL20]
			src_next = alu_src(i_opcode[3:0]);
			dst_next = `MCDEC_LOC_ACC;
			len_next = src_len(src_next);
		end else if (i_opcode[7:4] == 4'h7 && i_opcode[3:0] >= 4'h4) begin
			op_next  = `MCDEC_OP_MOV; // [RL13] [RL14] [RL15] [RL16]
			src_next = `MCDEC_LOC_IMM;
			dst_next = (i_opcode[3:0] == 4'h4) ? `MCDEC_LOC_ACC : alu_src(i_opcode[3:0]);
			len_next = (i_opcode[3:0] == 4'h5) ? `MCDEC_LEN_3 : `MCDEC_LEN_2;
			if (i_opcode[3:0] == 4'h5)
				cyc_next = mc_cnt(`MCDEC_MC_2);
		end else if ((i_opcode[7:4] == 4'h8 || i_opcode[7:4] == 4'ha) &&
			i_opcode[3:0] >= 4'h6) begin
			// Moves through the direct byte take two cycles.
			op_next  = `MCDEC_OP_MOV; // [RL14] [RL15] [RL16]
			cyc_next = mc_cnt(`MCDEC_MC_2);
			len_next = `MCDEC_LEN_2;
			if (i_opcode[7:4] == 4'h8) begin
				src_next = alu_src(i_opcode[3:0]);
				dst_next = `MCDEC_LOC_DIR;
			end else begin
				src_next = `MCDEC_LOC_DIR;
				dst_next = alu_src(i_opcode[3:0]);
			end
		end else begin
			case (i_opcode)
				8'h85: begin
					op_next  = `MCDEC_OP_MOV; // [RL15]
					src_next = `MCDEC_LOC_DIR;
					dst_next = `MCDEC_LOC_DIR;
					len_next = `MCDEC_LEN_3;
					cyc_next = mc_cnt(`MCDEC_MC_2);
				end
				8'ha4, 8'h84: begin
					op_next  = (i_opcode == 8'ha4) ? `MCDEC_OP_MUL : `MCDEC_OP_DIV; // [RL3]
					src_next = `MCDEC_LOC_ACC;
					dst_next = `MCDEC_LOC_ACC;
					cyc_next = mc_cnt(`MCDEC_MC_4);
				end
				8'h04, 8'h14: begin
					op_next  = i_opcode[4] ? `MCDEC_OP_DEC : `MCDEC_OP_INC; // [RL7] [RL8]
					src_next = `MCDEC_LOC_ACC;
					dst_next = `MCDEC_LOC_ACC;
				end
				8'ha3: begin
					op_next  = `MCDEC_OP_INC; // [RL7]
					src_next = `MCDEC_LOC_DATA_POINTER16;
					dst_next = `MCDEC_LOC_DATA_POINTER16;
					cyc_next = mc_cnt(`MCDEC_MC_2);
				end
				8'hd4, 8'he4, 8'hf4, 8'hc4, 8'h23, 8'h33, 8'h03, 8'h13: begin
					src_next = `MCDEC_LOC_ACC; // [RL8] [RL12]
					dst_next = `MCDEC_LOC_ACC;
					case (i_opcode)
						8'hd4: op_next = `MCDEC_OP_DA;
						8'he4: op_next = `MCDEC_OP_CLR;
						8'hf4: op_next = `MCDEC_OP_CPL;
						8'hc4: op_next = `MCDEC_OP_SWAP;
						8'h23: op_next = `MCDEC_OP_RL;
						8'h33: op_next = `MCDEC_OP_RLC;
						8'h03: op_next = `MCDEC_OP_RR;
						default: op_next = `MCDEC_OP_RRC;
					endcase
				end
				8'h42, 8'h52, 8'h62, 8'h43, 8'h53, 8'h63: begin
					op_next  = (i_opcode[6:4] == 3'h4) ? `MCDEC_OP_OR :
						(i_opcode[6:4] == 3'h5) ? `MCDEC_OP_AND : `MCDEC_OP_XOR; // [RL9]
					src_next = i_opcode[0] ? `MCDEC_LOC_IMM : `MCDEC_LOC_ACC; // [RL10] [RL11]
					dst_next = `MCDEC_LOC_DIR;
					len_next = i_opcode[0] ? `MCDEC_LEN_3 : `MCDEC_LEN_2;
					cyc_next = i_opcode[0] ? mc_cnt(`MCDEC_MC_2) :
						mc_cnt(`MCDEC_MC_1);
				end
				8'h93, 8'h83, 8'h90: begin
					op_next  = (i_opcode == 8'h90) ? `MCDEC_OP_MOV : `MCDEC_OP_MOVC; // [RL17]
					src_next = (i_opcode == 8'h90) ? `MCDEC_LOC_IMM16 :
						(i_opcode == 8'h93) ? `MCDEC_LOC_CODEA : `MCDEC_LOC_CODEP;
					dst_next = (i_opcode == 8'h90) ? `MCDEC_LOC_DATA_POINTER16 : `MCDEC_LOC_ACC;
					len_next = (i_opcode == 8'h90) ? `MCDEC_LEN_3 : `MCDEC_LEN_1;
					cyc_next = mc_cnt(`MCDEC_MC_2);
				end
				8'he2, 8'he3, 8'hf2, 8'hf3, 8'he0, 8'hf0: begin
					op_next  = `MCDEC_OP_MOVX; // [RL18]
					src_next = i_opcode[4] ? `MCDEC_LOC_ACC :
						(i_opcode[1] ? `MCDEC_LOC_XIND : `MCDEC_LOC_XDPTR);
					dst_next = !i_opcode[4] ? `MCDEC_LOC_ACC :
						(i_opcode[1] ? `MCDEC_LOC_XIND : `MCDEC_LOC_XDPTR);
					cyc_next = mc_cnt(`MCDEC_MC_2);
				end
				8'hc0, 8'hd0: begin
					op_next  = i_opcode[4] ? `MCDEC_OP_POP : `MCDEC_OP_PUSH; // [RL19]
					src_next = i_opcode[4] ? `MCDEC_LOC_STACK : `MCDEC_LOC_DIR;
					dst_next = i_opcode[4] ? `MCDEC_LOC_DIR : `MCDEC_LOC_STACK;
					len_next = `MCDEC_LEN_2;
					cyc_next = mc_cnt(`MCDEC_MC_2);
				end
				8'hd6, 8'hd7: begin
					op_next  = `MCDEC_OP_XCHD; // [RL20]
					src_next = `MCDEC_LOC_INDLO;
					dst_next = `MCDEC_LOC_ACC;
				end
				8'hc3, 8'hc2, 8'hd3, 8'hd2, 8'hb3, 8'hb2: begin
					op_next  = (i_opcode[7:4] == 4'hc) ? `MCDEC_OP_CLR :
						(i_opcode[7:4] == 4'hd) ? `MCDEC_OP_SETB : `MCDEC_OP_CPL; // [RL21]
					src_next = i_opcode[0] ? `MCDEC_LOC_CARRY : `MCDEC_LOC_BIT;
					dst_next = src_next;
					len_next = i_opcode[0] ? `MCDEC_LEN_1 : `MCDEC_LEN_2;
				end
				8'h82: begin
					op_next  = `MCDEC_OP_ANLC; // [RL22]
					src_next = `MCDEC_LOC_BIT;
					dst_next = `MCDEC_LOC_CARRY;
					len_next = `MCDEC_LEN_2;
					cyc_next = mc_cnt(`MCDEC_MC_2);
				end
				default: begin
					// Branches and the rest are not this block's; flag them undefined.
					def_next = 1'b0;
					len_next = `MCDEC_LEN_1;
				end
			endcase
		end
	end

	// An opcode is taken only while the timer is idle; later ones are dropped.
	assign accept_w = i_opcode_valid && !busy_w;

	// Registered so that outputs settle in the cycle after the opcode is fetched. [RL24]
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_valid         <= 1'b0;
			o_defined       <= 1'b0;
			o_op            <= `MCDEC_OP_NONE;
			o_src           <= `MCDEC_LOC_NONE;
			o_dst           <= `MCDEC_LOC_NONE;
			o_len           <= `MCDEC_LEN_1;
			o_cycles        <= mc_cnt(`MCDEC_MC_1);
			o_bank_register <= {`MCDEC_REG_W{1'b0}};
			o_exec_busy     <= 1'b0;
			o_exec_done     <= 1'b0;
		end else begin
			o_valid     <= accept_w;
			o_exec_busy <= busy_w;
			o_exec_done <= done_w;
			// Fields hold between accepted opcodes, so the sequencer may read them while busy.
			if (accept_w) begin
				o_defined       <= def_next;
				o_op            <= op_next; // [RL24]
				o_src           <= src_next;
				o_dst           <= dst_next;
				o_len           <= len_next; // [RL1]
				o_cycles        <= cyc_next; // [RL2]
				o_bank_register <= i_opcode[`MCDEC_REG_LSB +: `MCDEC_REG_W]; // [RL23]
			end
		end
	end

	// The timer paces execution; opcodes offered while it runs are ignored.
	mcdec_mc_timer #(
		.CNT_W (CNT_W)
	) u_timer (
		.i_clk    (i_clk),
		.i_nrst   (i_nrst),
		.i_start  (accept_w && def_next),
		.i_cycles (cyc_next),
		.o_busy   (busy_w),
		.o_done   (done_w)
	);
endmodule // mcdec_opcode_decoder

// ---- testbench/mcdec_fetch_model.sv ----
// Stand-in for the fetch unit: offers one opcode byte for one cycle per request.
module mcdec_fetch_model (
	input  wire logic       i_clk,
	input  wire logic       i_req,
	input  wire logic [7:0] i_req_opcode,
	output logic            o_opcode_valid = 1'b0,
	output logic [7:0]      o_opcode = 8'h00
);
	timeunit 1ns;
	timeprecision 100ps;
	// Between offers the byte lane toggles, so a stale opcode is never mistaken for a fresh one.
	always @(posedge i_clk) begin
		o_opcode_valid <= i_req;
		o_opcode       <= i_req ? i_req_opcode : ~o_opcode;
	end
endmodule // mcdec_fetch_model

// ---- testbench/mcdec_dec_props.sv ----
`include "mcdec_consts.vh"
module mcdec_dec_props #(
	parameter CNT_W = 3
) (
	input wire                    i_clk,
	input wire                    i_nrst,
	input wire [7:0]              i_opcode,
	input wire                    o_valid,
	input wire                    o_defined,
	input wire [1:0]              o_len,
	input wire [CNT_W-1:0]        o_cycles,
	input wire [`MCDEC_REG_W-1:0] o_bank_register,
	input wire                    o_exec_busy,
	input wire                    o_exec_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] op_q;
	always @(posedge i_clk) begin
		op_q <= i_opcode;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	property p_len_range; o_valid |-> o_len != 2'h0; endproperty
	a_len_range: assert property (p_len_range) else $error("bad length");
	property p_cycles_set;
		o_valid |-> (o_cycles == 1 || o_cycles == 2 || o_cycles == 4);
	endproperty
	a_cycles_set: assert property (p_cycles_set) else $error("bad cycle count");
	property p_bank_bits; o_valid |-> o_bank_register == op_q[2:0]; endproperty
	a_bank_bits: assert property (p_bank_bits) else $error("bad bank register");
	property p_muldiv;
		o_valid && (op_q == 8'ha4 || op_q == 8'h84) |-> o_cycles == 4 && o_len == 2'h1;
	endproperty
	a_muldiv: assert property (p_muldiv) else $error("bad multiply or divide");
	property p_undef_idle; o_valid && !o_defined |=> !o_exec_busy; endproperty
	a_undef_idle: assert property (p_undef_idle) else $error("undefined ran");
	property p_busy_1mc;
		o_valid && o_defined && o_cycles == 1 |=> o_exec_busy[*2] ##1 (!o_exec_busy && o_exec_done);
	endproperty
	a_busy_1mc: assert property (p_busy_1mc) else $error("one cycle time wrong");
	property p_busy_2mc;
		o_valid && o_defined && o_cycles == 2 |=> o_exec_busy[*4] ##1 (!o_exec_busy && o_exec_done);
	endproperty
	a_busy_2mc: assert property (p_busy_2mc) else $error("two cycle time wrong");
	property p_busy_4mc;
		o_valid && o_defined && o_cycles == 4 |=> o_exec_busy[*8] ##1 (!o_exec_busy && o_exec_done);
	endproperty
	a_busy_4mc: assert property (p_busy_4mc) else $error("four cycle time wrong");
	property p_hold;
		o_exec_busy |-> !o_valid && $stable(o_len) && $stable(o_cycles);
	endproperty
	a_hold: assert property (p_hold) else $error("accepted while busy");
	property p_done_pulse; o_exec_done |=> !o_exec_done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");
	c_mul: cover property (o_valid && op_q == 8'ha4);
	c_undef: cover property (o_valid && !o_defined);
	c_three: cover property (o_valid && o_len == 2'h3);
endmodule // mcdec_dec_props
bind mcdec_opcode_decoder mcdec_dec_props #(.CNT_W(CNT_W)) u_props (.i_clk(i_clk),
	.i_nrst(i_nrst), .i_opcode(i_opcode), .o_valid(o_valid), .o_defined(o_defined),
	.o_len(o_len), .o_cycles(o_cycles), .o_bank_register(o_bank_register),
	.o_exec_busy(o_exec_busy), .o_exec_done(o_exec_done));

// ---- testbench/mcdec_opcode_decoder_tb.sv ----
`include "mcdec_consts.vh"
module mcdec_opcode_decoder_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                    i_clk = 1'b0;
	logic                    i_nrst = 1'b0;
	logic                    req = 1'b0;
	logic [7:0]              req_op = 8'h00;
	wire                     opv, o_valid, o_defined, o_exec_busy, o_exec_done;
	wire [7:0]               opc;
	wire [`MCDEC_OP_W-1:0]   o_op;
	wire [`MCDEC_LOC_W-1:0]  o_src, o_dst;
	wire [1:0]               o_len;
	wire [2:0]               o_cycles, o_bank_register;
	integer                  failures = 0;
	integer                  n_compared = 0;
	initial forever #12.5 i_clk = ~i_clk;
	mcdec_fetch_model u_fetch (.i_clk(i_clk), .i_req(req), .i_req_opcode(req_op),
		.o_opcode_valid(opv), .o_opcode(opc));
	mcdec_opcode_decoder #(.CNT_W(3)) u_dut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_opcode_valid(opv), .i_opcode(opc), .o_valid(o_valid), .o_defined(o_defined),
		.o_op(o_op), .o_src(o_src), .o_dst(o_dst), .o_len(o_len), .o_cycles(o_cycles),
		.o_bank_register(o_bank_register), .o_exec_busy(o_exec_busy), .o_exec_done(o_exec_done));
	// Packs defined flag, byte length and machine cycles.
	function automatic logic [5:0] expv(input logic [7:0] o);
		case (o) inside
			8'ha4, 8'h84: expv = {1'h1, 2'h1, 3'h4};
			8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'h90: expv = {1'h1, 2'h3, 3'h2};
			[8'ha8:8'haf], [8'h88:8'h8f], 8'h86, 8'h87, 8'ha6, 8'ha7, 8'hc0, 8'hd0,
			8'h82: expv = {1'h1, 2'h2, 3'h2};
			8'ha3, 8'h93, 8'h83, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2,
			8'hf3: expv = {1'h1, 2'h1, 3'h2};
			8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95, 8'h05, 8'h15, 8'h52, 8'h54, 8'h55,
			8'h42, 8'h44, 8'h45, 8'h62, 8'h64, 8'h65, 8'he5, 8'h74, [8'h78:8'h7f], 8'hf5,
			8'h76, 8'h77, 8'hc5, 8'hc2, 8'hd2, 8'hb2: expv = {1'h1, 2'h2, 3'h1};
			[8'h28:8'h2f], [8'h38:8'h3f], [8'h98:8'h9f], [8'h08:8'h0f], [8'h18:8'h1f],
			[8'h58:8'h5f], [8'h48:8'h4f], [8'h68:8'h6f], [8'he8:8'hef], [8'hf8:8'hff],
			[8'hc8:8'hcf], 8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, 8'h04, 8'h06, 8'h07,
			8'h14, 8'h16, 8'h17, 8'hd4, 8'h56, 8'h57, 8'h46, 8'h47, 8'h66, 8'h67, 8'he4,
			8'hf4, 8'hc4, 8'h23, 8'h33, 8'h03, 8'h13, 8'he6, 8'he7, 8'hf6, 8'hf7, 8'hc6,
			8'hc7, 8'hd6, 8'hd7, 8'hc3, 8'hd3, 8'hb3: expv = {1'h1, 2'h1, 3'h1};
			default: expv = {1'h0, 2'h1, 3'h1};
		endcase
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic offer(input logic [7:0] op);
		@(posedge i_clk) begin req <= 1'b1; req_op <= op; end
		@(posedge i_clk) req <= 1'b0;
	endtask
	task automatic wait_valid;
		integer n;
		n = 0;
		while (o_valid !== 1'b1) begin
			@(posedge i_clk); #1;
			n++;
			if (n > 10) begin
				chk(8'h00, 8'h01);
				tally_and_finish;
			end
		end
	endtask
	// Counts busy cycles until the completion pulse; a timer that never finishes is a failure.
	task automatic wait_idle(output integer b);
		integer seen_done;
		b = 0;
		seen_done = 0;
		repeat (20) begin
			@(posedge i_clk); #1;
			if (o_exec_busy === 1'b1) b++;
			if (o_exec_done === 1'b1) begin
				seen_done = 1;
				break;
			end
		end
		chk(8'(seen_done), 8'h01);
		if (seen_done == 0) tally_and_finish;
	endtask
	task automatic t_sweep;
		integer i, b;
		logic [5:0] e;
		for (i = 0; i < 256; i++) begin
			offer(i[7:0]);
			wait_valid;
			e = expv(i[7:0]);
			chk(8'(o_defined), 8'(e[5]));
			chk(8'(o_len), 8'(e[4:3]));
			chk(8'(o_cycles), 8'(e[2:0]));
			chk(8'(o_bank_register), 8'(i[2:0]));
			if (e[5]) begin
				wait_idle(b);
				chk(8'(b), 8'(2 * e[2:0]));
			end
		end
		$display("test sweep done");
	endtask
	task automatic t_drop;
		integer b, seen;
		offer(8'ha4);
		wait_valid;
		chk(8'(o_op), 8'(`MCDEC_OP_MUL));
		offer(8'h04);
		seen = 0;
		repeat (10) begin
			@(posedge i_clk); #1;
			if (o_valid === 1'b1) seen = 1;
		end
		chk(8'(seen), 8'h00);
		chk(8'(o_cycles), 8'h04);
		offer(8'h84);
		wait_valid;
		chk(8'(o_op), 8'(`MCDEC_OP_DIV));
		wait_idle(b);
		chk(8'(b), 8'h08);
		$display("test drop done");
	endtask
	// Offers one opcode and checks its class and operand locations.
	task automatic chk_fields(input logic [7:0] op, input logic [4:0] cls,
		input logic [3:0] src, input logic [3:0] dst);
		integer b;
		offer(op);
		wait_valid;
		chk(8'(o_op), 8'(cls));
		chk(8'(o_src), 8'(src));
		chk(8'(o_dst), 8'(dst));
		wait_idle(b);
	endtask
	task automatic t_fields;
		chk_fields(8'h2b, `MCDEC_OP_ADD, `MCDEC_LOC_REG, `MCDEC_LOC_ACC);
		chk_fields(8'h36, `MCDEC_OP_ADDC, `MCDEC_LOC_IND, `MCDEC_LOC_ACC);
		chk_fields(8'h94, `MCDEC_OP_SUBB, `MCDEC_LOC_IMM, `MCDEC_LOC_ACC);
		chk_fields(8'h05, `MCDEC_OP_INC, `MCDEC_LOC_DIR, `MCDEC_LOC_DIR);
		chk_fields(8'h1a, `MCDEC_OP_DEC, `MCDEC_LOC_REG, `MCDEC_LOC_REG);
		chk_fields(8'h53, `MCDEC_OP_AND, `MCDEC_LOC_IMM, `MCDEC_LOC_DIR);
		chk_fields(8'h42, `MCDEC_OP_OR, `MCDEC_LOC_ACC, `MCDEC_LOC_DIR);
		chk_fields(8'h67, `MCDEC_OP_XOR, `MCDEC_LOC_IND, `MCDEC_LOC_ACC);
		chk_fields(8'h13, `MCDEC_OP_RRC, `MCDEC_LOC_ACC, `MCDEC_LOC_ACC);
		chk_fields(8'he5, `MCDEC_OP_MOV, `MCDEC_LOC_DIR, `MCDEC_LOC_ACC);
		chk_fields(8'ha9, `MCDEC_OP_MOV, `MCDEC_LOC_DIR, `MCDEC_LOC_REG);
		chk_fields(8'h87, `MCDEC_OP_MOV, `MCDEC_LOC_IND, `MCDEC_LOC_DIR);
		chk_fields(8'h76, `MCDEC_OP_MOV, `MCDEC_LOC_IMM, `MCDEC_LOC_IND);
		chk_fields(8'h90, `MCDEC_OP_MOV, `MCDEC_LOC_IMM16, `MCDEC_LOC_DATA_POINTER16);
		chk_fields(8'h83, `MCDEC_OP_MOVC, `MCDEC_LOC_CODEP, `MCDEC_LOC_ACC);
		chk_fields(8'hf0, `MCDEC_OP_MOVX, `MCDEC_LOC_ACC, `MCDEC_LOC_XDPTR);
		chk_fields(8'he3, `MCDEC_OP_MOVX, `MCDEC_LOC_XIND, `MCDEC_LOC_ACC);
		chk_fields(8'hd0, `MCDEC_OP_POP, `MCDEC_LOC_STACK, `MCDEC_LOC_DIR);
		chk_fields(8'hd7, `MCDEC_OP_XCHD, `MCDEC_LOC_INDLO, `MCDEC_LOC_ACC);
		chk_fields(8'hb2, `MCDEC_OP_CPL, `MCDEC_LOC_BIT, `MCDEC_LOC_BIT);
		chk_fields(8'hc3, `MCDEC_OP_CLR, `MCDEC_LOC_CARRY, `MCDEC_LOC_CARRY);
		chk_fields(8'h82, `MCDEC_OP_ANLC, `MCDEC_LOC_BIT, `MCDEC_LOC_CARRY);
		$display("test fields done");
	endtask
	task automatic t_reset;
		integer b;
		offer(8'h53);
		wait_valid;
		@(posedge i_clk) i_nrst <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		chk({o_valid, o_exec_busy, o_len, o_cycles}, 8'h09);
		chk(8'(o_op), 8'(`MCDEC_OP_NONE));
		@(posedge i_clk) i_nrst <= 1'b1;
		offer(8'ha3);
		wait_valid;
		chk(8'(o_cycles), 8'h02);
		wait_idle(b);
		chk(8'(b), 8'h04);
		$display("test reset done");
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		t_sweep;
		t_drop;
		t_fields;
		t_reset;
		tally_and_finish;
	end
endmodule // mcdec_opcode_decoder_tb
